// File: test/lgm_monitor.sv
// Concurrent checks on the gray-level mapper ports.
`default_nettype none
module lgm_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [1:0]  gray_depth_option,
   input wire logic [7:0]  ram_byte,
   input wire logic        ram_valid,
   input wire logic [39:0] segment_line_level_r,
   input wire logic [7:0]  segment_line_valid_r,
   input wire logic        segment_line_strobe_r
);
   timeunit 1ns;
   timeprecision 1ps;
   wire        st = segment_line_strobe_r;
   wire [39:0] lv = segment_line_level_r;
   wire [7:0]  vd = segment_line_valid_r;
   wire [1:0]  op = gray_depth_option;
   wire        go = hsel && hready && htrans[1];
   wire        eq = lv[4:0] == lv[9:5];
   logic [7:0] pb_r;
   // Byte behind the current strobe, so equal codes can be compared.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pb_r <= 8'h00;
      else pb_r <= ram_byte;
   end
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ****
   // Assertions
   // ****
   strobe_cause_a: assert property (st |-> $past(ram_valid))
      else $error("strobe without an offered byte");
   level_hold_a: assert property (!st |-> $stable(lv))
      else $error("levels moved without a strobe");
   lane_mask_a: assert property (st && $past(op, 4) == op |->
      vd == (op == 2'h0 ? 8'h03 : op == 2'h1 ? 8'h0f : 8'hff))
      else $error("lane mask does not fit the depth");
   nibble_lane_a: assert property (st && vd == 8'h03 &&
      pb_r[3:0] == pb_r[7:4] |-> eq)
      else $error("equal nibbles gave unequal levels");
   pair_lane_a: assert property (st && vd == 8'h0f &&
      pb_r[1:0] == pb_r[3:2] |-> eq)
      else $error("equal pairs gave unequal levels");
   bit_lane_a: assert property (st && vd == 8'hff &&
      pb_r[0] == pb_r[1] |-> eq)
      else $error("equal bits gave unequal levels");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus response not ready and okay");
   map_read_a: assert property (go && !hwrite &&
      haddr[7:0] == 8'h04 |=> hrdata == 32'h0000_0000)
      else $error("shared map port read back data");
   ptr_clear_a: assert property ((go && hwrite &&
      haddr[7:0] == 8'h00) ##1 !hwdata[5] ##1 (go && !hwrite &&
      haddr[7:0] == 8'h08) |=> hrdata[3:0] == 4'h0)
      else $error("pointer not cleared by control write");
endmodule // lgm_monitor
`default_nettype wire

// File: test/lgm_panel_model.sv
// Behavioural model of the panel segment drivers.
`default_nettype none
module lgm_panel_model (
   input  wire logic        clk,
   input  wire logic [39:0] level,
   input  wire logic [7:0]  valid,
   input  wire logic        strobe,
   output var  logic        got,
   output var  logic [39:0] lvl,
   output var  logic [7:0]  vld
);
   timeunit 1ns;
   timeprecision 1ps;
   // The panel registers level and valid on every clock; got marks the cycle after the strobe stands.
   always @(posedge clk) begin
      got <= strobe;
      lvl <= level;
      vld <= valid;
   end
endmodule // lgm_panel_model
`default_nettype wire

// File: test/lgm_top_tb_top.sv
// Self-checking bench for the gray-level mapper.
`default_nettype none
module lgm_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, ram_valid, full, en;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans, gray_depth_option;
   logic [2:0]  hsize;
   logic [7:0]  ram_byte;
   logic [3:0]  ptr;
   logic [4:0]  mp [16];
   logic [47:0] expq [$];
   wire         hreadyout, hresp, segment_line_strobe_r, pgot;
   wire  [31:0] hrdata;
   wire  [39:0] segment_line_level_r, plvl;
   wire  [7:0]  segment_line_valid_r, pvld;
   int          mismatches = 0;
   int          n_tests = 0;
   int          i;
   lgm_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .gray_depth_option, .ram_byte, .ram_valid, .segment_line_level_r,
      .segment_line_valid_r, .segment_line_strobe_r);
   lgm_panel_model panel (.clk(hclk), .level(segment_line_level_r),
      .valid(segment_line_valid_r), .strobe(segment_line_strobe_r),
      .got(pgot), .lvl(plvl), .vld(pvld));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic bad(input string m);
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic wrap_up;
      $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) bad("read data differs");
   endtask
   task automatic cmp_px(input logic [47:0] g, input logic [47:0] e);
      n_tests++;
      if (g !== e) bad("segment levels differ");
   endtask
   // Samples ready and read data at the rising edge that ends a phase.
   task automatic wt(output logic [31:0] r);
      int k;
      logic rdy;
      k = 0;
      do begin
         @(posedge hclk);
         rdy = hreadyout;
         r = hrdata;
         k++;
      end while (rdy !== 1'b1 && k < 40);
      if (rdy !== 1'b1) begin
         bad("bus wait ran out");
         wrap_up();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wt(r);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt(r);
   endtask
   task automatic mw(input logic [31:0] d);
      bus(1'b1, 8'h04, d, rd);
      mp[ptr] = d[4:0];
      if (ptr == 4'hf) full = 1'b1;
      ptr = ptr + 4'h1;
   endtask
   task automatic cw(input logic [31:0] d);
      bus(1'b1, 8'h00, d, rd);
      en = d[0];
      if (!d[5]) {ptr, full} = 5'h00;
   endtask
   task automatic sr;
      bus(1'b0, 8'h08, 32'h0000_0000, rd);
      cmp_rd(rd, {23'h0, full, 2'h0, gray_depth_option, ptr});
   endtask
   task automatic mrst;
      for (i = 0; i < 16; i++) mp[i] = 5'(2 * i);
      {ptr, full, en} = 6'h01;
   endtask
   function automatic logic [47:0] ex(input logic [7:0] b);
      logic [39:0] l;
      logic [7:0] v;
      l = '0;
      case (gray_depth_option)
         2'h0: begin
            v = 8'h03;
            l[9:0] = {mp[b[7:4]], mp[b[3:0]]};
         end
         2'h1: begin
            v = 8'h0f;
            for (int k = 0; k < 4; k++) l[5*k+:5] = mp[b[2*k+:2]];
         end
         default: begin
            v = 8'hff;
            for (int k = 0; k < 8; k++) l[5*k+:5] = mp[b[k]];
         end
      endcase
      return {v, l};
   endfunction
   task automatic px(input logic [7:0] b);
      ram_byte <= b;
      ram_valid <= 1'b1;
      if (en) expq.push_back(ex(b));
      @(posedge hclk);
   endtask
   task automatic batch;
      px(8'h33);
      px(8'h05);
      px(8'h03);
      repeat (12) px(8'($urandom));
      ram_valid <= 1'b0;
      repeat (3) @(posedge hclk);
      n_tests++;
      if (expq.size() != 0) bad("strobe missing");
   endtask
   // Each panel capture takes the oldest note; unused lanes are masked.
   always @(posedge hclk) begin
      logic [39:0] m;
      logic [47:0] e;
      if (pgot === 1'b1) begin
         m = '0;
         if (expq.size() == 0) begin
            n_tests++;
            bad("strobe with nothing sent");
         end else begin
            e = expq.pop_front();
            for (int k = 0; k < 8; k++) if (e[40+k]) m[5*k+:5] = 5'h1f;
            cmp_px({pvld, plvl & m}, e);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge hclk);
      bad("run hung");
      wrap_up();
   end
   // ****
   // Main sequence
   // ****
   initial begin
      {hresetn, hsel, hwrite, ram_valid, htrans, hsize} = 9'h002;
      {haddr, hwdata, ram_byte, gray_depth_option} = 74'h0;
      mrst();
      void'($urandom(32'h5bd3_1af6));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0, rd);
      cmp_rd(rd, 32'h0000_0021);
      bus(1'b0, 8'h04, 32'h0, rd);
      cmp_rd(rd, 32'h0000_0000);
      bus(1'b0, 8'h0c, 32'h0, rd);
      cmp_rd(rd, 32'h0000_0000);
      batch();
      repeat (3) mw($urandom);
      cw(32'h0000_0001);
      sr();
      cw(32'h0000_0021);
      repeat (16) mw($urandom);
      sr();
      mw($urandom);
      sr();
      for (i = 0; i < 4; i++) begin
         gray_depth_option <= 2'(i);
         repeat (4) @(posedge hclk);
         sr();
         batch();
      end
      cw(32'h0000_0020);
      px(8'h5a);
      ram_valid <= 1'b0;
      repeat (3) @(posedge hclk);
      cw(32'h0000_0021);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      mrst();
      repeat (4) @(posedge hclk);
      batch();
      wrap_up();
   end
endmodule // lgm_top_tb_top
bind lgm_top lgm_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
   .gray_depth_option, .ram_byte, .ram_valid, .segment_line_level_r,
   .segment_line_valid_r, .segment_line_strobe_r);
`default_nettype wire

// File: verilog/lgm_consts.vh
// Constants shared by the gray-level mapper design files.
`ifndef LGM_CONSTS_VH
`define LGM_CONSTS_VH

// ****************************************************************
// Gray depth option encodings
// ****************************************************************
`define LGM_DEPTH_16        2'h0
`define LGM_DEPTH_4         2'h1

// ****************************************************************
// Pixel and map geometry
// ****************************************************************
`define LGM_PIX_PER_BYTE    8
`define LGM_CODE_W          4
`define LGM_LEVEL_W         5
`define LGM_MAP_DEPTH       16
`define LGM_PTR_W           4
`define LGM_PTR_FIRST       4'h0
`define LGM_PTR_LAST        4'hf

// ****************************************************************
// Register byte offsets and fields
// ****************************************************************
`define LGM_ADDR_W          8
`define LGM_OFF_CTRL        8'h00
`define LGM_OFF_MAP         8'h04
`define LGM_OFF_STAT        8'h08
`define LGM_CTRL_W          8
`define LGM_CTRL_EN_BIT     0
`define LGM_CTRL_PTR_BIT    5
`define LGM_CTRL_RESET      8'h21
`define LGM_STAT_PTR_LSB    0
`define LGM_STAT_DEPTH_LSB  4
`define LGM_STAT_FULL_BIT   8
`define LGM_HTRANS_NONSEQ   2'h2
`define LGM_HRESP_OKAY      1'b0
`define LGM_WORD_ZERO       32'h0000_0000

// ****************************************************************
// Map register reset values
// ****************************************************************
`define LGM_MAP_RST_0       5'h00
`define LGM_MAP_RST_1       5'h02
`define LGM_MAP_RST_2       5'h04
`define LGM_MAP_RST_3       5'h06
`define LGM_MAP_RST_4       5'h08
`define LGM_MAP_RST_5       5'h0a
`define LGM_MAP_RST_6       5'h0c
`define LGM_MAP_RST_7       5'h0e
`define LGM_MAP_RST_8       5'h10
`define LGM_MAP_RST_9       5'h12
`define LGM_MAP_RST_10      5'h14
`define LGM_MAP_RST_11      5'h16
`define LGM_MAP_RST_12      5'h18
`define LGM_MAP_RST_13      5'h1a
`define LGM_MAP_RST_14      5'h1c
`define LGM_MAP_RST_15      5'h1e

`endif

// File: verilog/lgm_top.v
// Gray-level mapper: AHB-Lite registers, map bank and pixel translation.
`default_nettype none
`include "lgm_consts.vh"

module lgm_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire [1:0]  gray_depth_option,
   input  wire [7:0]  ram_byte,
   input  wire        ram_valid,
   output reg  [39:0] segment_line_level_r,
   output reg  [7:0]  segment_line_valid_r,
   output reg         segment_line_strobe_r
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg  [1:0]                depth_meta_r;
   reg  [1:0]                depth_r;
   reg                       ph_write_r;
   reg                       ph_valid_r;
   reg  [`LGM_ADDR_W-1:0]    ph_addr_r;
   reg  [`LGM_CTRL_W-1:0]    lcd_control_register_r;
   reg  [`LGM_CTRL_W-1:0]    lcd_control_register_nxt;
   reg  [`LGM_PTR_W-1:0]     map_ptr_r;
   reg  [`LGM_PTR_W-1:0]     map_ptr_nxt;
   reg                       map_full_r;
   reg                       map_full_nxt;
   reg  [`LGM_LEVEL_W-1:0]   gray_level_map_bank [0:`LGM_MAP_DEPTH-1];
   reg  [31:0]               hrdata_nxt;
   reg  [39:0]               level_nxt;
   wire [31:0]               unpack_codes;
   wire [7:0]                unpack_mask;
   wire                      addr_phase;
   wire                      wr_ctrl;
   wire                      wr_map;
   wire                      ptr_clear;
   wire                      disp_enable;
   integer                   i;
   integer                   s;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Reset value of each map register.
   function [`LGM_LEVEL_W-1:0] map_reset;
      input integer idx;
      begin
         case (idx)
            0:       map_reset = `LGM_MAP_RST_0;
            1:       map_reset = `LGM_MAP_RST_1;
            2:       map_reset = `LGM_MAP_RST_2;
            3:       map_reset = `LGM_MAP_RST_3;
            4:       map_reset = `LGM_MAP_RST_4;
            5:       map_reset = `LGM_MAP_RST_5;
            6:       map_reset = `LGM_MAP_RST_6;
            7:       map_reset = `LGM_MAP_RST_7;
            8:       map_reset = `LGM_MAP_RST_8;
            9:       map_reset = `LGM_MAP_RST_9;
            10:      map_reset = `LGM_MAP_RST_10;
            11:      map_reset = `LGM_MAP_RST_11;
            12:      map_reset = `LGM_MAP_RST_12;
            13:      map_reset = `LGM_MAP_RST_13;
            14:      map_reset = `LGM_MAP_RST_14;
            default: map_reset = `LGM_MAP_RST_15;
         endcase
      end
   endfunction

   // Limits a code to the map registers that the current depth may use.
   function [`LGM_PTR_W-1:0] map_index;
      input [`LGM_CODE_W-1:0] code;
      input [1:0]             depth;
      begin
         case (depth)
            `LGM_DEPTH_16: map_index = code;
            `LGM_DEPTH_4:  map_index = {2'b00, code[1:0]};
            default:       map_index = {3'b000, code[0]};
         endcase
      end
   endfunction

   // True when the registered address phase targets the given offset.
   function hits;
      input [`LGM_ADDR_W-1:0] addr;
      input [`LGM_ADDR_W-1:0] offset;
      begin
         hits = (addr == offset);
      end
   endfunction

   // ****************************************************************
   // Depth option synchroniser
   // ****************************************************************

   // The option is a static strap, but it still passes two flops.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         depth_meta_r <= `LGM_DEPTH_16;
         depth_r      <= `LGM_DEPTH_16;
      end else begin
         depth_meta_r <= gray_depth_option;
         depth_r      <= depth_meta_r;
      end
   end

   // ****************************************************************
   // AHB-Lite address phase capture
   // ****************************************************************
   assign hreadyout  = 1'b1;
   assign hresp      = `LGM_HRESP_OKAY;
   assign addr_phase = hsel & hready & htrans[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r  <= `LGM_OFF_CTRL;
      end else begin
         ph_valid_r <= addr_phase;
         ph_write_r <= addr_phase & hwrite;
         ph_addr_r  <= haddr[`LGM_ADDR_W-1:0];
      end
   end

   assign wr_ctrl = ph_write_r & hits(ph_addr_r, `LGM_OFF_CTRL);
   assign wr_map  = ph_write_r & hits(ph_addr_r, `LGM_OFF_MAP);

   // ****************************************************************
   // Read data
   // ****************************************************************

   // Read data is formed in the address phase and stands in the next.
   always @* begin
      hrdata_nxt = `LGM_WORD_ZERO;
      if (addr_phase && !hwrite) begin
         case (haddr[`LGM_ADDR_W-1:0])
            `LGM_OFF_CTRL: begin
               hrdata_nxt[`LGM_CTRL_W-1:0] = lcd_control_register_nxt;
            end
            `LGM_OFF_STAT: begin
               hrdata_nxt[`LGM_STAT_PTR_LSB +: `LGM_PTR_W] = map_ptr_nxt;
               hrdata_nxt[`LGM_STAT_DEPTH_LSB +: 2]        = depth_r;
               hrdata_nxt[`LGM_STAT_FULL_BIT]              = map_full_nxt;
            end
            default: begin
               hrdata_nxt = `LGM_WORD_ZERO;
            end
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `LGM_WORD_ZERO;
      end else begin
         hrdata <= hrdata_nxt;
      end
   end

   // ****************************************************************
   // LCD control register
   // ****************************************************************
   always @* begin
      lcd_control_register_nxt = lcd_control_register_r;
      if (wr_ctrl) begin
         lcd_control_register_nxt = hwdata[`LGM_CTRL_W-1:0];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lcd_control_register_r <= `LGM_CTRL_RESET;
      end else begin
         lcd_control_register_r <= lcd_control_register_nxt;
      end
   end

   // A write that leaves the pointer bit low restarts the map sequence.
   assign ptr_clear   = wr_ctrl & ~hwdata[`LGM_CTRL_PTR_BIT];
   assign disp_enable = lcd_control_register_r[`LGM_CTRL_EN_BIT];

   // ****************************************************************
   // Shared map port write pointer
   // ****************************************************************
   always @* begin
      map_ptr_nxt  = map_ptr_r;
      map_full_nxt = map_full_r;
      if (ptr_clear) begin
         map_ptr_nxt  = `LGM_PTR_FIRST;
         map_full_nxt = 1'b0;
      end else if (wr_map) begin
         map_ptr_nxt = map_ptr_r + 4'h1;
         if (map_ptr_r == `LGM_PTR_LAST) begin
            map_full_nxt = 1'b1;
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         map_ptr_r  <= `LGM_PTR_FIRST;
         map_full_r <= 1'b0;
      end else begin
         map_ptr_r  <= map_ptr_nxt;
         map_full_r <= map_full_nxt;
      end
   end

   // ****************************************************************
   // Gray-level map bank
   // ****************************************************************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < `LGM_MAP_DEPTH; i = i + 1) begin
            gray_level_map_bank[i] <= map_reset(i);
         end
      end else if (wr_map) begin
         gray_level_map_bank[map_ptr_r] <=
            hwdata[`LGM_LEVEL_W-1:0];
      end
   end

   // ****************************************************************
   // Pixel unpacking
   // ****************************************************************
   lgm_unpack u_unpack (
      .ram_byte (ram_byte),
      .depth    (depth_r),
      .codes    (unpack_codes),
      .seg_mask (unpack_mask)
   );

   // ****************************************************************
   // Code to physical level translation
   // ****************************************************************
   always @* begin
      level_nxt = 40'h00_0000_0000;
      for (s = 0; s < `LGM_PIX_PER_BYTE; s = s + 1) begin
         if (unpack_mask[s]) begin
            level_nxt[s*5 +: 5] = gray_level_map_bank[
               map_index(unpack_codes[s*4 +: 4], depth_r)];
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         segment_line_level_r  <= 40'h00_0000_0000;
         segment_line_valid_r  <= 8'h00;
         segment_line_strobe_r <= 1'b0;
      end else begin
         segment_line_strobe_r <= ram_valid & disp_enable;
         if (ram_valid && disp_enable) begin
            segment_line_level_r <= level_nxt;
            segment_line_valid_r <= unpack_mask;
         end
      end
   end

endmodule // lgm_top
`default_nettype wire

// File: verilog/lgm_unpack.v
// Pixel code extraction from one display RAM byte.
`default_nettype none
`include "lgm_consts.vh"

module lgm_unpack (
   input  wire [7:0]  ram_byte,
   input  wire [1:0]  depth,
   output reg  [31:0] codes,
   output reg  [7:0]  seg_mask
);

   integer k;

   // ****************************************************************
   // Byte to per-segment code slices
   // ****************************************************************
   always @* begin
      codes    = `LGM_WORD_ZERO;
      seg_mask = 8'h00;
      case (depth)
         `LGM_DEPTH_16: begin
            codes[3:0] = ram_byte[3:0];
            codes[7:4] = ram_byte[7:4];
            seg_mask   = 8'h03;
         end
         `LGM_DEPTH_4: begin
            for (k = 0; k < 4; k = k + 1) begin
               codes[k*4 +: 4] = {2'b00, ram_byte[k*2 +: 2]};
            end
            seg_mask = 8'h0f;
         end
         default: begin
            for (k = 0; k < 8; k = k + 1) begin
               codes[k*4 +: 4] = {3'b000, ram_byte[k]};
            end
            seg_mask = 8'hff;
         end
      endcase
   end

endmodule // lgm_unpack
`default_nettype wire
